// *** design/sse_check.sv ***
// Combinational decode, address formation and trap priority
`timescale 1ns/1ps
module sse_check #(
  parameter logic [13:0][7:0] VALID_ASIS = {8'h04, 8'h0C, 8'h10, 8'h11, 8'h18, 8'h19,
                                            8'h14, 8'h1C, 8'h15, 8'h1D, 8'h80, 8'h88,
                                            8'h81, 8'h89}
) (
  sse_chk_if.chk ifc
);
  logic [5:0] sec_op;
  logic [4:0] rd;
  logic       imm_sel;
  logic       pad_dirty;
  logic       asi_ok;

  assign sec_op    = ifc.instr[24:19];
  assign rd        = ifc.instr[29:25];
  assign imm_sel   = ifc.instr[13];
  assign pad_dirty = (ifc.instr[12:5] != 8'h00);

  // Operand and effective address
  assign ifc.op2 = imm_sel ? sse_pkg::sse_sext13(ifc.instr[12:0]) : ifc.src2;
  assign ifc.ea  = ifc.src1 + ifc.op2;
  // Space comes from the instruction or the space register
  assign ifc.asi = imm_sel ? ifc.asi_reg : ifc.instr[12:5];

  // Whitelist; nontranslating spaces fall outside it on purpose
  always_comb
  begin
    asi_ok = 1'b0;
    for (int k = 0; k < 14; k++)
    begin
      if (ifc.asi == VALID_ASIS[k])
        asi_ok = 1'b1;
    end
  end

  // Opcode decode
  always_comb
  begin
    ifc.kind = sse_pkg::K_NONE;
    if (ifc.instr[31:30] == sse_pkg::OP_ARITH)
    begin
      case (sec_op)
        sse_pkg::OP3_SUB:    ifc.kind = sse_pkg::K_SUB;
        sse_pkg::OP3_SUBCC:  ifc.kind = sse_pkg::K_SUBCC;
        sse_pkg::OP3_SUBC:   ifc.kind = sse_pkg::K_SUBC;
        sse_pkg::OP3_SUBCCC: ifc.kind = sse_pkg::K_SUBCCC;
        default:             ifc.kind = sse_pkg::K_NONE;
      endcase
    end
    else if (ifc.instr[31:30] == sse_pkg::OP_MEM)
    begin
      case (sec_op)
        sse_pkg::OP3_TWIN_ALT: ifc.kind = sse_pkg::K_TWIN;
        sse_pkg::OP3_SWAP:     ifc.kind = sse_pkg::K_SWAP;
        sse_pkg::OP3_FSR:      ifc.kind = (rd == sse_pkg::FSR_RD_LOWER) ? sse_pkg::K_FSR32
                                                                        : sse_pkg::K_FSR64;
        default:               ifc.kind = sse_pkg::K_NONE;
      endcase
    end
  end

  // Trap priority: illegal, float off, misalign, privilege, space
  always_comb
  begin
    ifc.trap = sse_pkg::T_NONE;
    case (ifc.kind)
      sse_pkg::K_TWIN:
      begin
        if (rd[0])
          ifc.trap = sse_pkg::T_ILLEGAL;
        else if (ifc.ea[2:0] != 3'h0)
          ifc.trap = sse_pkg::T_MISALIGN;
        else if (!ifc.priv && !ifc.asi[sse_pkg::ASI_UNRES_BIT])
          ifc.trap = sse_pkg::T_PRIV_ACT;
        else if (ifc.priv && ifc.asi >= sse_pkg::ASI_PRIV_LO && ifc.asi <= sse_pkg::ASI_PRIV_HI)
          ifc.trap = sse_pkg::T_PRIV_ACT;
        else if (!asi_ok)
          ifc.trap = sse_pkg::T_DATA_ACC;
      end
      sse_pkg::K_FSR64, sse_pkg::K_FSR32:
      begin
        if ((!imm_sel && pad_dirty) || rd > sse_pkg::FSR_RD_FULL)
          ifc.trap = sse_pkg::T_ILLEGAL;
        else if (!ifc.fef || !ifc.pef || !ifc.fpu_ok)
          ifc.trap = sse_pkg::T_FP_OFF;
        else if (ifc.kind == sse_pkg::K_FSR64 && ifc.ea[2:0] != 3'h0)
          ifc.trap = sse_pkg::T_MISALIGN;
        else if (ifc.kind == sse_pkg::K_FSR32 && ifc.ea[1:0] != 2'h0)
          ifc.trap = sse_pkg::T_MISALIGN;
      end
      sse_pkg::K_SWAP:
      begin
        if (!imm_sel && pad_dirty)
          ifc.trap = sse_pkg::T_ILLEGAL;
        else if (ifc.ea[1:0] != 2'h0)
          ifc.trap = sse_pkg::T_MISALIGN;
      end
      sse_pkg::K_SUB, sse_pkg::K_SUBCC, sse_pkg::K_SUBC, sse_pkg::K_SUBCCC:
      begin
        if (!imm_sel && pad_dirty)
          ifc.trap = sse_pkg::T_ILLEGAL;
      end
      default: ifc.trap = sse_pkg::T_NONE;
    endcase
  end
endmodule

// *** design/sse_chk_if.sv ***
// Bundle between the executor and its decode/trap checker
`timescale 1ns/1ps
interface sse_chk_if;
  logic [31:0]       instr;
  logic [63:0]       src1;
  logic [63:0]       src2;
  logic [7:0]        asi_reg;
  logic              priv;
  logic              pef;
  logic              fef;
  logic              fpu_ok;
  sse_pkg::sse_kind_t kind;
  sse_pkg::sse_trap_t trap;
  logic [63:0]       ea;
  logic [63:0]       op2;
  logic [7:0]        asi;
  modport chk (input instr, src1, src2, asi_reg, priv, pef, fef, fpu_ok,
               output kind, trap, ea, op2, asi);
  modport user (output instr, src1, src2, asi_reg, priv, pef, fef, fpu_ok,
                input kind, trap, ea, op2, asi);
endinterface

// *** design/sse_exec.sv ***
// Executor for twin store, state store, subtract family and swap
// What this block does
// - Alternate twin-word store runs in hardware; never raises unimplemented trap.
// - Twin store with odd destination register raises illegal instruction.
// - Twin store address not eight-byte aligned raises misaligned address.
// - User mode with space bit 7 clear raises privileged action.
// - Privileged mode with space 30 to 7F raises privileged action.
// - Twin store accepts only the listed spaces; others raise data access.
// - Nontranslating spaces on twin store raise data access.
// - State store waits for float operations, then stores all 64 bits (rd 1) or the lower 32 (rd 0).
// - Trap-type field cleared only after the store is known trap-free.
// - State opcode: rd 1 full, rd 0 lower, rd 2-31 illegal.
// - State store with any float enable off raises float-off trap.
// - Full state store not eight-byte aligned raises misaligned address.
// - Register-form subtract, swap and state store with bits 12:5 nonzero raise illegal instruction.
// - Address is sum of sources, or source plus sign-extended immediate.
// - Four subtract opcodes decode to plain, cc, carry, carry-cc.
// - Result is source minus operand, minus 32-bit carry for carry forms.
// - Cc forms update both flag sets; 32-bit overflow from bit 31.
// - 64-bit overflow from bit 63 signs of operands and result.
// - Swap exchanges low word, zeroes upper half, blocks interrupts meanwhile.
// - Memory serialises competing atomics; we hold the lock throughout.
// - Swap uses implicit space and needs four-byte alignment.
// - Twin store writes even register at address, odd one at plus 4.
// - Twin store space from instruction field or space register.
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module sse_exec (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Register bus
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Issue side
  input  wire logic        issue_valid_in,
  input  wire logic [31:0] instr_in,
  input  wire logic [63:0] src1_in,
  input  wire logic [63:0] src2_in,
  input  wire logic [63:0] rd_val_in,
  input  wire logic [63:0] rd_pair_val_in,
  input  wire logic [7:0]  asi_reg_in,
  input  wire logic        privilege_mode_bit_in,
  input  wire logic        proc_fp_enable_bit_in,
  input  wire logic [63:0] fsr_in,
  input  wire logic [7:0]  ccr_in,
  input  wire logic        fp_busy_in,
  // Memory side
  input  wire logic        mem_ack_in,
  input  wire logic        mem_fault_in,
  input  wire logic [31:0] mem_rdata_in,
  output logic             mem_req_out,
  output logic             mem_write_out,
  output logic             mem_swap_out,
  output logic             mem_lock_out,
  output logic             mem_dword_out,
  output logic      [63:0] mem_addr_out,
  output logic      [7:0]  mem_asi_out,
  output logic      [63:0] mem_wdata_out,
  // Results
  output logic             ready_out,
  output logic             done_out,
  output logic             trap_out,
  output logic      [2:0]  trap_code_out,
  output logic             rd_we_out,
  output logic      [63:0] rd_data_out,
  output logic             ccr_we_out,
  output logic      [7:0]  ccr_out,
  output logic             ftt_clear_out,
  output logic             irq_hold_out
);
  localparam logic [7:0] IMPLICIT_ASI = 8'h80; // Primary space tag for implicit accesses

  sse_pkg::sse_top_t s, n;
  sse_chk_if         ifc ();

  // Checker inputs straight from the issue port; float enables fef and fpu_ok from the control register
  assign ifc.instr   = instr_in;
  assign ifc.src1    = src1_in;
  assign ifc.src2    = src2_in;
  assign ifc.asi_reg = asi_reg_in;
  assign ifc.priv    = privilege_mode_bit_in;
  assign ifc.pef     = proc_fp_enable_bit_in;
  assign ifc.fef     = s.ctrl[sse_pkg::CTRL_FEF_BIT];
  assign ifc.fpu_ok  = s.ctrl[sse_pkg::CTRL_FPU_BIT];

  sse_check u_check (
    .ifc (ifc.chk)
  );

  // Next-state logic for bus slave, sequencer and results
  always_comb
  begin
    logic [64:0] d64;
    logic [32:0] d32;
    logic        cin;
    logic [1:0]  ctrl_now;
    d64      = '0;
    d32      = '0;
    cin      = 1'b0;
    ctrl_now = s.ctrl;
    n        = s;
    n.done      = 1'b0;
    n.trap      = 1'b0;
    n.rd_we     = 1'b0;
    n.ccr_we    = 1'b0;
    n.ftt_clear = 1'b0;
    n.hready    = 1'b1;

    // Data phase of a write lands here; no wait states
    if (s.hwr_pend && s.hwr_ofs == sse_pkg::CTRL_OFS)
    begin
      n.ctrl   = hwdata_in[1:0];
      ctrl_now = hwdata_in[1:0]; // Forward so back-to-back read sees it
    end
    n.hwr_pend = 1'b0;
    if (hsel_in && hready_in && htrans_in[1])
    begin
      n.hwr_pend = hwrite_in;
      n.hwr_ofs  = haddr_in;
      n.hrdata   = 32'h0000_0000; // Unmapped reads as zero, still OKAY
      if (!hwrite_in && haddr_in == sse_pkg::CTRL_OFS)
        n.hrdata = {30'h0, ctrl_now};
      else if (!hwrite_in && haddr_in == sse_pkg::STATUS_OFS)
        n.hrdata = {s.trap_cnt, 12'h000, s.last_trap, !s.ready};
    end

    case (s.st)
      sse_pkg::S_IDLE:
      begin
        if (issue_valid_in && s.ready)
        begin
          n.kind    = ifc.kind;
          n.ea      = ifc.ea;
          n.second  = 1'b0;
          n.pair_lo = rd_pair_val_in[31:0];
          if (ifc.trap != sse_pkg::T_NONE)
          begin
            // Nothing reaches memory once a trap is known
            n.trap      = 1'b1;
            n.trap_code = ifc.trap;
            n.last_trap = ifc.trap;
            n.trap_cnt  = s.trap_cnt + 16'h0001;
          end
          else
          begin
            case (ifc.kind)
              sse_pkg::K_SUB, sse_pkg::K_SUBCC, sse_pkg::K_SUBC, sse_pkg::K_SUBCCC:
              begin
                // Only the 32-bit carry feeds the carry forms
                cin = (ifc.kind == sse_pkg::K_SUBC || ifc.kind == sse_pkg::K_SUBCCC)
                      && ccr_in[sse_pkg::CC_C];
                d64 = {1'b0, src1_in} - {1'b0, ifc.op2} - {64'h0, cin};
                d32 = {1'b0, src1_in[31:0]} - {1'b0, ifc.op2[31:0]} - {32'h0, cin};
                n.rd_we   = 1'b1;
                n.rd_data = d64[63:0];
                n.done    = 1'b1;
                if (ifc.kind == sse_pkg::K_SUBCC || ifc.kind == sse_pkg::K_SUBCCC)
                begin
                  n.ccr_we = 1'b1;
                  // Flags in N Z V C order, xcc above icc
                  n.ccr = {d64[63], d64[63:0] == 64'h0,
                           sse_pkg::sse_ovf(src1_in[63], ifc.op2[63], d64[63]), d64[64],
                           d32[31], d32[31:0] == 32'h0,
                           sse_pkg::sse_ovf(src1_in[31], ifc.op2[31], d32[31]), d32[32]};
                end
              end
              sse_pkg::K_FSR64, sse_pkg::K_FSR32:
              begin
                n.st    = sse_pkg::S_FPWAIT;
                n.ready = 1'b0;
              end
              sse_pkg::K_TWIN:
              begin
                // Handled here, no emulation trap path exists
                n.mem_req   = 1'b1;
                n.mem_write = 1'b1;
                n.mem_swap  = 1'b0;
                n.mem_lock  = 1'b1; // Pair is atomic
                n.mem_dword = 1'b0;
                n.mem_addr  = ifc.ea;
                n.mem_asi   = ifc.asi;
                n.mem_wdata = {32'h0, rd_val_in[31:0]};
                n.st        = sse_pkg::S_MEM;
                n.ready     = 1'b0;
              end
              sse_pkg::K_SWAP:
              begin
                n.mem_req   = 1'b1;
                n.mem_write = 1'b1;
                n.mem_swap  = 1'b1;
                n.mem_lock  = 1'b1;
                n.mem_dword = 1'b0;
                n.mem_addr  = ifc.ea;
                n.mem_asi   = IMPLICIT_ASI;
                n.mem_wdata = {32'h0, rd_val_in[31:0]};
                n.st        = sse_pkg::S_MEM;
                n.ready     = 1'b0;
              end
              default: n.done = 1'b1; // Not in this group: complete quietly
            endcase
          end
        end
      end
      sse_pkg::S_FPWAIT:
      begin
        // Hold until the float pipe drains so the stored state is final
        if (!fp_busy_in)
        begin
          n.mem_req   = 1'b1;
          n.mem_write = 1'b1;
          n.mem_swap  = 1'b0;
          n.mem_lock  = 1'b0;
          n.mem_dword = (s.kind == sse_pkg::K_FSR64);
          n.mem_addr  = s.ea;
          n.mem_asi   = IMPLICIT_ASI;
          n.mem_wdata = (s.kind == sse_pkg::K_FSR64) ? fsr_in : {32'h0, fsr_in[31:0]};
          n.st        = sse_pkg::S_MEM;
        end
      end
      sse_pkg::S_MEM:
      begin
        if (mem_ack_in)
        begin
          n.mem_req = 1'b0;
          if (mem_fault_in)
          begin
            // Faulting store leaves the trap-type field alone
            n.trap      = 1'b1;
            n.trap_code = sse_pkg::T_MEM_FAULT;
            n.last_trap = sse_pkg::T_MEM_FAULT;
            n.trap_cnt  = s.trap_cnt + 16'h0001;
            n.mem_lock  = 1'b0;
            n.st        = sse_pkg::S_IDLE;
            n.ready     = 1'b1;
          end
          else if (s.kind == sse_pkg::K_TWIN && !s.second)
          begin
            // Odd register word follows at address plus 4
            n.second    = 1'b1;
            n.mem_req   = 1'b1;
            n.mem_addr  = s.ea + sse_pkg::TWIN_STEP;
            n.mem_wdata = {32'h0, s.pair_lo};
          end
          else
          begin
            if (s.kind == sse_pkg::K_SWAP)
            begin
              n.rd_we   = 1'b1;
              n.rd_data = {32'h0, mem_rdata_in};
            end
            n.ftt_clear = (s.kind == sse_pkg::K_FSR64 || s.kind == sse_pkg::K_FSR32);
            n.done      = 1'b1;
            n.mem_lock  = 1'b0;
            n.st        = sse_pkg::S_IDLE;
            n.ready     = 1'b1;
          end
        end
      end
      default: n.st = sse_pkg::S_IDLE;
    endcase
  end

  // One register stage for all state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s       <= '0;
      s.st    <= sse_pkg::S_IDLE;
      s.ctrl  <= sse_pkg::CTRL_RESET;
      s.ready <= 1'b1;
      s.hready <= 1'b1;
    end
    else
      s <= n;
  end

  // Outputs straight from the state register, except hresp_out tied low (OKAY)
  assign hrdata_out    = s.hrdata;
  assign hreadyout_out = s.hready;
  assign hresp_out     = 1'b0;
  assign mem_req_out   = s.mem_req;
  assign mem_write_out = s.mem_write;
  assign mem_swap_out  = s.mem_swap;
  assign mem_lock_out  = s.mem_lock;
  assign mem_dword_out = s.mem_dword;
  assign mem_addr_out  = s.mem_addr;
  assign mem_asi_out   = s.mem_asi;
  assign mem_wdata_out = s.mem_wdata;
  assign ready_out     = s.ready;
  assign done_out      = s.done;
  assign trap_out      = s.trap;
  assign trap_code_out = s.trap_code;
  assign rd_we_out     = s.rd_we;
  assign rd_data_out   = s.rd_data;
  assign ccr_we_out    = s.ccr_we;
  assign ccr_out       = s.ccr;
  assign ftt_clear_out = s.ftt_clear;
  assign irq_hold_out  = s.mem_lock; // Interrupts held off while atomic runs

  // Checks
  logic take;
  assign take = issue_valid_in && s.ready;

  chk_fp_store_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(s.mem_req) && s.st == sse_pkg::S_MEM && s.mem_dword |-> $past(!fp_busy_in))
    else $error("state store issued while float ops pending");
  chk_ftt_after_ok: assert property (@(posedge clk_in) disable iff (rst_in)
    ftt_clear_out |-> $past(mem_ack_in && !mem_fault_in) && !trap_out)
    else $error("trap-type cleared without a clean store");
  chk_swap_upper_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_we_out && s.kind == sse_pkg::K_SWAP |-> rd_data_out[63:32] == 32'h0
      && rd_data_out[31:0] == $past(mem_rdata_in))
    else $error("swap result not the zero-extended memory word");
  chk_twin_second_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    s.kind == sse_pkg::K_TWIN && $rose(s.second) |-> mem_addr_out == s.ea + sse_pkg::TWIN_STEP
      && mem_wdata_out[31:0] == s.pair_lo)
    else $error("second twin word at wrong address or data");
  chk_atomic_lock: assert property (@(posedge clk_in) disable iff (rst_in)
    mem_req_out && (s.kind == sse_pkg::K_SWAP || s.kind == sse_pkg::K_TWIN)
      |-> mem_lock_out && irq_hold_out)
    else $error("atomic access without interrupt hold");
  chk_sub_value: assert property (@(posedge clk_in) disable iff (rst_in)
    take && ifc.trap == sse_pkg::T_NONE && ifc.kind == sse_pkg::K_SUB
      |=> rd_we_out && rd_data_out == $past(src1_in - ifc.op2))
    else $error("plain subtract result wrong");
  chk_trap_no_mem: assert property (@(posedge clk_in) disable iff (rst_in)
    take && ifc.trap != sse_pkg::T_NONE |=> trap_out && !mem_req_out && ready_out)
    else $error("trapped instruction reached memory");
  chk_ovf_icc: assert property (@(posedge clk_in) disable iff (rst_in)
    take && ifc.trap == sse_pkg::T_NONE && ifc.kind == sse_pkg::K_SUBCC
      |=> ccr_we_out && ccr_out[sse_pkg::CC_V] == sse_pkg::sse_ovf($past(src1_in[31]),
          $past(ifc.op2[31]), rd_data_out[31]))
    else $error("32-bit overflow flag wrong");
  chk_bad_space: assert property (@(posedge clk_in) disable iff (rst_in)
    take && ifc.kind == sse_pkg::K_TWIN && ifc.trap == sse_pkg::T_DATA_ACC
      |=> trap_code_out == sse_pkg::T_DATA_ACC ##1 !mem_req_out)
    else $error("unlisted space not refused");
endmodule

// *** design/sse_pkg.sv ***
// Shared constants, types and helpers for the store/subtract/swap executor
package sse_pkg;
  // Register map and fields
  localparam logic [31:0] CTRL_OFS       = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS     = 32'h0000_0004;
  localparam int          CTRL_FEF_BIT   = 0;
  localparam int          CTRL_FPU_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h3;
  localparam int          STAT_TRAP_LSB  = 1;
  localparam int          STAT_CNT_LSB   = 16;
  // Instruction encodings
  localparam logic [1:0]  OP_ARITH       = 2'h2;
  localparam logic [1:0]  OP_MEM         = 2'h3;
  localparam logic [5:0]  OP3_SUB        = 6'h04;
  localparam logic [5:0]  OP3_SUBCC      = 6'h14;
  localparam logic [5:0]  OP3_SUBC       = 6'h0C;
  localparam logic [5:0]  OP3_SUBCCC     = 6'h1C;
  localparam logic [5:0]  OP3_TWIN_ALT   = 6'h17;
  localparam logic [5:0]  OP3_FSR        = 6'h25;
  localparam logic [5:0]  OP3_SWAP       = 6'h0F;
  localparam logic [4:0]  FSR_RD_LOWER   = 5'h00;
  localparam logic [4:0]  FSR_RD_FULL    = 5'h01;
  // Address space checks
  localparam logic [7:0]  ASI_PRIV_LO    = 8'h30;
  localparam logic [7:0]  ASI_PRIV_HI    = 8'h7F;
  localparam int          ASI_UNRES_BIT  = 7;
  localparam logic [63:0] TWIN_STEP      = 64'h0000_0000_0000_0004;
  // Condition code bit positions: icc in [3:0], xcc in [7:4]
  localparam int          CC_C           = 0;
  localparam int          CC_V           = 1;
  localparam int          XCC_BASE       = 4;

  typedef enum logic [3:0] {K_NONE, K_SUB, K_SUBCC, K_SUBC, K_SUBCCC,
                            K_FSR64, K_FSR32, K_TWIN, K_SWAP} sse_kind_t;
  typedef enum logic [2:0] {T_NONE, T_ILLEGAL, T_FP_OFF, T_MISALIGN,
                            T_PRIV_ACT, T_DATA_ACC, T_MEM_FAULT} sse_trap_t;
  typedef enum logic [1:0] {S_IDLE, S_FPWAIT, S_MEM} sse_state_t;

  typedef struct packed {
    sse_state_t  st;
    logic [1:0]  ctrl;
    logic        hwr_pend;
    logic [31:0] hwr_ofs;
    logic [31:0] hrdata;
    logic        hready;
    sse_kind_t   kind;
    logic [63:0] ea;
    logic        second;
    logic [31:0] pair_lo;
    logic [15:0] trap_cnt;
    sse_trap_t   last_trap;
    logic        mem_req;
    logic        mem_write;
    logic        mem_swap;
    logic        mem_lock;
    logic        mem_dword;
    logic [63:0] mem_addr;
    logic [7:0]  mem_asi;
    logic [63:0] mem_wdata;
    logic        ready;
    logic        done;
    logic        trap;
    sse_trap_t   trap_code;
    logic        rd_we;
    logic [63:0] rd_data;
    logic        ccr_we;
    logic [7:0]  ccr;
    logic        ftt_clear;
  } sse_top_t;

  // Signed overflow of a subtraction from the three sign bits
  function automatic logic sse_ovf(input logic a, input logic b, input logic r);
    return (a != b) && (r != a);
  endfunction

  // Sign extension of the 13-bit immediate
  function automatic logic [63:0] sse_sext13(input logic [12:0] v);
    return {{51{v[12]}}, v};
  endfunction
endpackage

// *** verif/sse_mem_model.sv ***
// Memory responder for the executor's store and swap requests
`timescale 1ns/1ps
module sse_mem_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic        slow_in,
  input  wire logic [31:0] old_in,
  output logic             ack_out,
  output logic      [31:0] rdata_out
);
  logic [1:0] cnt_reg = 2'h0;
  // One request served at a time, promptly or after three waits
  always @(posedge clk_in)
  begin
    ack_out <= req_in && !ack_out && cnt_reg == (slow_in ? 2'h3 : 2'h0);
    cnt_reg <= (req_in && !ack_out) ? cnt_reg + 2'h1 : 2'h0;
  end
  // Inverted word outside ack, so stale data cannot pass
  assign rdata_out = ack_out ? old_in : ~old_in;
endmodule

// *** verif/store_subtract_swap_exec_test.sv ***
// Self-checking bench for the store, subtract and swap executor
`timescale 1ns/1ps
module store_subtract_swap_exec_test;
  localparam logic [63:0] RDV = 64'hFFFF_FFFF_CAFE_0001;
  localparam logic [63:0] RDP = 64'h0BAD_F00D_7777_1111;
  localparam logic [31:0] OLD = 32'h5555_AAAA;
  logic        clk_in = 1'h0, rst_in = 1'h1, hsel = 1'h0, hwrite = 1'h0, iv = 1'h0, lk, ack;
  logic        priv = 1'h1, pef = 1'h1, busy = 1'h0, slow = 1'h0, hrdy, mreq, mlock, rdy;
  logic        done, trap, rdwe, ccrwe, ftt, irqh;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  tcode, fl;
  logic [7:0]  asir = 8'h81, masi, ccro, la;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, instr = 32'h0, hrdata, q, rdat;
  logic [63:0] s1 = 64'h0, s2 = 64'h0, rdd, maddr, mwd, wa[$], wd[$];
  int          n_errors = 0, checks = 0, nb = 0;
  sse_exec sse_exec_inst (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(),
    .issue_valid_in(iv), .instr_in(instr), .src1_in(s1), .src2_in(s2), .rd_val_in(RDV),
    .rd_pair_val_in(RDP), .asi_reg_in(asir), .privilege_mode_bit_in(priv),
    .proc_fp_enable_bit_in(pef), .fsr_in(64'h1234_5678_9ABC_DEF0), .ccr_in(8'h01),
    .fp_busy_in(busy), .mem_ack_in(ack), .mem_fault_in(maddr[10]), .mem_rdata_in(rdat),
    .mem_req_out(mreq), .mem_write_out(), .mem_swap_out(), .mem_lock_out(mlock),
    .mem_dword_out(), .mem_addr_out(maddr), .mem_asi_out(masi), .mem_wdata_out(mwd),
    .ready_out(rdy), .done_out(done), .trap_out(trap), .trap_code_out(tcode),
    .rd_we_out(rdwe), .rd_data_out(rdd), .ccr_we_out(ccrwe), .ccr_out(ccro),
    .ftt_clear_out(ftt), .irq_hold_out(irqh));
  sse_mem_model sse_mem_model_inst (.clk_in(clk_in), .req_in(mreq), .slow_in(slow),
    .old_in(OLD), .ack_out(ack), .rdata_out(rdat));
  initial forever #2 clk_in = ~clk_in;
  // Log finished transfers; any request while float work is busy counts
  always @(posedge clk_in)
  begin
    if (mreq && busy) nb++;
    if (mreq && ack) begin wa.push_back(maddr); wd.push_back(mwd); la = masi; lk = mlock & irqh; end
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin n_errors++; $display("MISMATCH %0t got %h want %h", $time, seen, exp); end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait: 0 bus ready, 1 issue ready, 2 done or trap
  task automatic wt(input int m);
    repeat (80) begin @(posedge clk_in); if ((m == 0 ? hrdy : m == 1 ? rdy : done | trap) === 1'h1) return; end
    n_errors++;
    give_verdict();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in); hsel <= 1'h1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    wt(0); hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    wt(0); q = hrdata;
  endtask
  function automatic logic [31:0] mk(input logic [1:0] o, input logic [4:0] rd,
                                     input logic [5:0] p, input logic i, input logic [12:0] l);
    return {o, rd, p, 5'h0, i, l};
  endfunction
  task automatic run(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
                     input logic [2:0] ec);
    @(posedge clk_in); instr <= ins; s1 <= a; s2 <= b; iv <= 1'h1;
    wt(1); iv <= 1'h0;
    wt(2); fl = {ftt, ccrwe, rdwe};
    chk(trap, ec != 3'h0);
    if (ec != 3'h0) chk(tcode, ec);
  endtask
  task automatic tw(input logic [4:0] r, input logic [7:0] a, input logic [63:0] e, input logic p,
                    input logic [2:0] ec);
    priv <= p;
    run(mk(2'h3, r, sse_pkg::OP3_TWIN_ALT, 1'h0, {a, 5'h0}), e, 64'h0, ec);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'h0;
    // Subtract family: table of the four opcodes, carry-in set
    for (int k = 0; k < 4; k++)
    begin
      run(mk(2'h2, 5'h3, k[1] ? (k[0] ? 6'h1C : 6'h0C) : (k[0] ? 6'h14 : 6'h04), 1'h0, 13'h1),
          64'h8000_0000_0000_0000, 64'h1, 3'h0);
      chk(rdd, 64'h7FFF_FFFF_FFFF_FFFF - k[1]);
      chk({fl[1], k[0] ? {ccro[5], ccro[1]} : 2'h2}, {k[0], 2'h2});
    end
    run(mk(2'h2, 5'h3, sse_pkg::OP3_SUBCC, 1'h0, 13'h1), 64'h8000_0000, 64'h1, 3'h0);
    chk({rdd, ccro[5], ccro[1]}, {64'h7FFF_FFFF, 2'h1});
    run(mk(2'h2, 5'h3, sse_pkg::OP3_SUB, 1'h1, 13'h1FFF), 64'h5, 64'h0, 3'h0);
    chk(rdd, 64'h6);
    run(mk(2'h2, 5'h3, sse_pkg::OP3_SUB, 1'h0, 13'h20), 64'h5, 64'h0, 3'h1);
    // Twin store refusals, then one accepted pair through the space register
    tw(5'h3, 8'h80, 64'h0, 1'h1, 3'h1);
    tw(5'h2, 8'h80, 64'h4, 1'h1, 3'h3);
    tw(5'h2, 8'h04, 64'h0, 1'h0, 3'h4);
    tw(5'h2, 8'h30, 64'h0, 1'h1, 3'h4);
    tw(5'h2, 8'h7F, 64'h0, 1'h1, 3'h4);
    tw(5'h2, 8'h20, 64'h0, 1'h1, 3'h5);
    tw(5'h2, 8'hA0, 64'h0, 1'h0, 3'h5);
    run(mk(2'h3, 5'h2, sse_pkg::OP3_TWIN_ALT, 1'h1, 13'h8), 64'h100, 64'h0, 3'h0);
    chk({wa[0], wa[1]}, {64'h108, 64'h10C});
    chk({wd[0][31:0], wd[1][31:0], la}, {RDV[31:0], RDP[31:0], 8'h81});
    // State store held off by busy float work, slow memory
    wd.delete(); busy <= 1'h1; slow <= 1'h1;
    fork
      run(mk(2'h3, 5'h1, sse_pkg::OP3_FSR, 1'h1, 13'h8), 64'h200, 64'h0, 3'h0);
      begin repeat (6) @(posedge clk_in); busy <= 1'h0; end
    join
    chk({wd[0], nb, fl[2]}, {64'h1234_5678_9ABC_DEF0, 32'h0, 1'h1});
    run(mk(2'h3, 5'h1, sse_pkg::OP3_FSR, 1'h1, 13'h8), 64'h400, 64'h0, 3'h6);
    chk(fl[2], 1'h0);
    run(mk(2'h3, 5'h1, sse_pkg::OP3_FSR, 1'h1, 13'hC), 64'h200, 64'h0, 3'h3);
    chk(fl[2], 1'h0);
    run(mk(2'h3, 5'h2, sse_pkg::OP3_FSR, 1'h1, 13'h8), 64'h200, 64'h0, 3'h1);
    run(mk(2'h3, 5'h1, sse_pkg::OP3_FSR, 1'h0, 13'h20), 64'h200, 64'h0, 3'h1);
    run(mk(2'h3, 5'h0, sse_pkg::OP3_FSR, 1'h1, 13'h4), 64'h200, 64'h0, 3'h0);
    for (int k = 0; k < 3; k++)
    begin
      ahb(1'h1, sse_pkg::CTRL_OFS, {30'h0, ~k[0], k[0] | k[1]});
      pef <= (k != 2);
      run(mk(2'h3, 5'h1, sse_pkg::OP3_FSR, 1'h1, 13'h8), 64'h200, 64'h0, 3'h2);
    end
    pef <= 1'h1; slow <= 1'h0;
    ahb(1'h1, sse_pkg::CTRL_OFS, 32'h3);
    ahb(1'h0, sse_pkg::CTRL_OFS, 32'h0);
    chk(q, 32'h3);
    ahb(1'h0, 32'h10, 32'h0);
    chk(q, 32'h0);
    // Swap: old word comes back zero-extended under the lock
    wa.delete(); wd.delete();
    run(mk(2'h3, 5'h4, sse_pkg::OP3_SWAP, 1'h1, 13'h0), 64'h300, 64'h0, 3'h0);
    chk({rdd, wd[0][31:0], lk}, {32'h0, OLD, RDV[31:0], 1'h1});
    chk({wa[0], la}, {64'h300, 8'h80});
    run(mk(2'h3, 5'h4, sse_pkg::OP3_SWAP, 1'h1, 13'h2), 64'h300, 64'h0, 3'h3);
    give_verdict();
  end
endmodule
